//--- rtl/fmc_pkg.sv
// package: register map, field positions, reset values and carrier types for the fan monitor bank
package fmc_pkg;
	localparam logic [7:0] FMC_ADDR_CFG6     = 8'h10;
	localparam logic [7:0] FMC_ADDR_CFG7     = 8'h11;
	localparam logic [7:0] FMC_ADDR_TEMP_B   = 8'h1A;
	localparam logic [7:0] FMC_ADDR_TEMP_C   = 8'h1B;
	localparam logic [7:0] FMC_ADDR_TEMP_D   = 8'h1C;
	localparam logic [7:0] FMC_ADDR_CURMON   = 8'h1D;
	localparam logic [7:0] FMC_ADDR_TERMV    = 8'h1E;
	localparam logic [7:0] FMC_ADDR_EXTRES   = 8'h1F;
	localparam logic [7:0] FMC_ADDR_TEMP_A   = 8'h33;
	localparam logic [7:0] FMC_CFG6_RST      = 8'h00;
	localparam logic [7:0] FMC_CFG7_RST      = 8'h00;
	localparam logic [7:0] FMC_TEMP_RST      = 8'h80;
	localparam logic [7:0] FMC_MEAS_RST      = 8'h00;
	localparam logic [7:0] FMC_CFG6_WMASK    = 8'hC7;
	localparam logic [7:0] FMC_CFG7_WMASK    = 8'h1F;
	localparam logic [7:0] FMC_CFG7_UNLOCKED = 8'h02;
	localparam logic [7:0] FMC_UNMAPPED_DATA = 8'h00;
	localparam logic [3:0] FMC_EXT_RSVD      = 4'h0;
	localparam int FMC_B_SLOW_R1   = 0;
	localparam int FMC_B_SLOW_LOC  = 1;
	localparam int FMC_B_SLOW_R2   = 2;
	localparam int FMC_B_VLOW      = 6;
	localparam int FMC_B_XSLOW     = 7;
	localparam int FMC_B_HYS_DIS   = 0;
	localparam int FMC_B_FULL_SPD  = 1;
	localparam int FMC_B_WATTS     = 2;
	localparam int FMC_B_SPIN_DIS  = 3;
	localparam int FMC_B_TO_DIS    = 4;
	localparam int FMC_NUM_TEMP    = 4;

	// one register access from the serial bus engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fmc_req_type;

	// a ten-bit measurement result from the converter
	typedef struct packed {
		logic       valid;
		logic [9:0] value;
	} fmc_meas_type;
endpackage

//--- rtl/fmc_sleep_ctrl.sv
// core-voltage-low sleep sequencer: status flag, alert, hot monitor gate, spin-up on wake
`timescale 1ns/10ps
`default_nettype none
module fmc_sleep_ctrl
	import fmc_pkg::*;
(
	input  wire logic clk,            // system clock
	input  wire logic arst_n,         // async reset, active low
	input  wire logic sleep_en,       // core-voltage-low behaviour enabled
	input  wire logic on_standby,     // running from standby supply (synchronised)
	input  wire logic vcore_below,    // core voltage below its low limit (synchronised)
	input  wire logic alert_en,       // alert output enabled
	input  wire logic status_clr,     // status flag clear pulse
	output logic      status_ff,      // sticky core-voltage-low status
	output logic      alert_ff,       // alert output level
	output logic      hot_mon_en_ff,  // processor-hot monitoring enabled
	output logic      spinup_req_ff   // one-cycle spin-up request on wake
);
	typedef enum logic [0:0] {
		FMC_AWAKE  = 1'b0,
		FMC_ASLEEP = 1'b1
	} fmc_sleep_type;

	fmc_sleep_type st_ff, nxt_st;
	logic          nxt_status;
	logic          nxt_alert;
	logic          nxt_hot;
	logic          nxt_spin;
	logic          enter;

	always_comb begin
		enter      = sleep_en && on_standby && vcore_below;
		nxt_st     = st_ff;
		nxt_spin   = 1'b0;
		nxt_status = status_ff;
		if (status_clr) begin
			nxt_status = 1'b0;
		end
		unique case (st_ff)
			FMC_AWAKE: begin
				if (enter) begin
					nxt_st = FMC_ASLEEP;
				end
			end
			FMC_ASLEEP: begin
				if (!vcore_below) begin
					nxt_st   = FMC_AWAKE;
					nxt_spin = 1'b1;
				end
			end
		endcase
		if (enter) begin
			nxt_status = 1'b1;
		end
		nxt_alert = nxt_status && alert_en;
		nxt_hot   = (nxt_st == FMC_AWAKE);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff         <= FMC_AWAKE;
			status_ff     <= 1'b0;
			alert_ff      <= 1'b0;
			hot_mon_en_ff <= 1'b1;
			spinup_req_ff <= 1'b0;
		end else begin
			st_ff         <= nxt_st;
			status_ff     <= nxt_status;
			alert_ff      <= nxt_alert;
			hot_mon_en_ff <= nxt_hot;
			spinup_req_ff <= nxt_spin;
		end
	end
endmodule
`default_nettype wire

//--- rtl/fmc_regbank.sv
// register bank: two configuration registers and the reading registers of the fan monitor
// How it works
// - cfg6 bits 0..2 each multiply one channel's fan smoothing times by four.
// - cfg6 bit 7 lengthens all smoothing times by a further 39.2 percent.
// - vcore-low sleep on standby sets status, raises alert, stops hot monitoring.
// - when vcore recovers, hot monitoring resumes and the spin-up request pulses in the same cycle.
// - lock bit makes both config registers read-only, except full-speed bit.
// - hysteresis is on after reset; cfg7 bit 0 set turns it off.
// - cfg7 bit 1 drives fans at maximum duty; resets 0, never locked.
// - cfg7 bit 3 holds pwm high for whole spin-up timeout, no pulse exit.
// - cfg7 bit 4 set disables the 35 ms bus timeout.
// - four read-only cpu temperature registers, one per client.
// - cpu temperature registers read 0x80 after power-on until updated.
// - current-monitor and termination-voltage registers hold 8 msbs, reset zero.
// - cfg6 resets to all zeros.
// - extended register holds term-voltage lsbs at 5:4, current-monitor lsbs at 7:6.
// - reading extended register freezes it and the msb registers until read.
`timescale 1ns/10ps
`default_nettype none
module fmc_regbank
	import fmc_pkg::*;
#(
	parameter int NUM_TEMP = FMC_NUM_TEMP
)(
	input  wire logic         clk,              // system clock, 20 MHz
	input  wire logic         arst_n,           // async reset, active low
	input  wire fmc_req_type  req,              // register access, one-cycle strobes
	input  wire logic         lock,             // lock bit of configuration register 1
	input  wire logic [7:0]   temp_in [NUM_TEMP], // cpu temperature from clients a..d
	input  wire logic [NUM_TEMP-1:0] temp_vld,  // new temperature pulse per client
	input  wire fmc_meas_type current_monitor_input,     // current-monitor result
	input  wire fmc_meas_type termination_voltage_input, // termination-voltage result
	input  wire logic         standby_pin,      // running from standby supply (async)
	input  wire logic         vcore_low_pin,    // core voltage below low limit (async)
	input  wire logic         alert_en,         // alert output enabled
	input  wire logic         status_clr,       // clear core-voltage-low status
	output logic [7:0]        rdata_ff,         // read data, valid cycle after rd
	output logic              rvalid_ff,        // read data strobe
	output logic [2:0]        slow_x4_ff,       // x4 smoothing: remote1, local, remote2
	output logic              extended_smoothing_ff,     // extra 39.2 percent smoothing
	output logic              overtemp_hysteresis_disable_ff, // hysteresis off
	output logic              full_speed_override_ff,    // all fans at max duty
	output logic              watts_display_flag_ff,     // watts display hint
	output logic              pulse_spinup_disable_ff,   // spin-up for full timeout
	output logic              bus_timeout_disable_ff,    // bus timeout off
	output logic              vlow_status_ff,   // core-voltage-low status bit
	output logic              alert_ff,         // alert output
	output logic              hot_mon_en_ff,    // processor-hot monitoring enabled
	output logic              spinup_req_ff     // wake spin-up request pulse
);
	logic [7:0] cfg6_ff, nxt_cfg6;
	logic [7:0] cfg7_ff, nxt_cfg7;
	logic [7:0] temp_ff [NUM_TEMP];
	logic [7:0] nxt_temp [NUM_TEMP];
	logic [9:0] cmon_ff, nxt_cmon;
	logic [9:0] tvolt_ff, nxt_tvolt;
	logic       frz_ff, nxt_frz;
	logic       cmon_rd_ff, nxt_cmon_rd;
	logic       tvolt_rd_ff, nxt_tvolt_rd;
	logic [7:0] nxt_rdata;
	logic [1:0] stby_sync_ff, vlow_sync_ff;
	logic       wr6, wr7;

	always_comb begin
		wr6      = req.wr && (req.addr == FMC_ADDR_CFG6);
		wr7      = req.wr && (req.addr == FMC_ADDR_CFG7);
		nxt_cfg6 = cfg6_ff;
		nxt_cfg7 = cfg7_ff;
		if (wr6 && !lock) begin
			nxt_cfg6 = req.wdata & FMC_CFG6_WMASK;
		end
		if (wr7) begin
			if (lock) begin
				nxt_cfg7 = (cfg7_ff & ~FMC_CFG7_UNLOCKED)
					| (req.wdata & FMC_CFG7_UNLOCKED);
			end else begin
				nxt_cfg7 = req.wdata & FMC_CFG7_WMASK;
			end
		end
	end

	// temperature holding registers, one per client
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TEMP; gi++) begin : g_temp
			always_comb begin
				nxt_temp[gi] = temp_vld[gi] ? temp_in[gi] : temp_ff[gi];
			end
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					temp_ff[gi] <= FMC_TEMP_RST;
				end else begin
					temp_ff[gi] <= nxt_temp[gi];
				end
			end
		end
	endgenerate

	// freeze after extended read; release when both msb registers are read
	always_comb begin
		nxt_frz      = frz_ff;
		nxt_cmon_rd  = cmon_rd_ff;
		nxt_tvolt_rd = tvolt_rd_ff;
		if (req.rd && req.addr == FMC_ADDR_EXTRES) begin
			nxt_frz      = 1'b1;
			nxt_cmon_rd  = 1'b0;
			nxt_tvolt_rd = 1'b0;
		end else if (frz_ff && req.rd) begin
			if (req.addr == FMC_ADDR_CURMON) begin
				nxt_cmon_rd = 1'b1;
			end
			if (req.addr == FMC_ADDR_TERMV) begin
				nxt_tvolt_rd = 1'b1;
			end
		end
		if (frz_ff && nxt_cmon_rd && nxt_tvolt_rd) begin
			nxt_frz = 1'b0;
		end
		nxt_cmon  = cmon_ff;
		nxt_tvolt = tvolt_ff;
		if (current_monitor_input.valid && !frz_ff) begin
			nxt_cmon = current_monitor_input.value;
		end
		if (termination_voltage_input.valid && !frz_ff) begin
			nxt_tvolt = termination_voltage_input.value;
		end
	end

	always_comb begin
		nxt_rdata = FMC_UNMAPPED_DATA;
		unique case (req.addr)
			FMC_ADDR_CFG6:   nxt_rdata = cfg6_ff;
			FMC_ADDR_CFG7:   nxt_rdata = cfg7_ff;
			FMC_ADDR_TEMP_A: nxt_rdata = temp_ff[0];
			FMC_ADDR_TEMP_B: nxt_rdata = temp_ff[1];
			FMC_ADDR_TEMP_C: nxt_rdata = temp_ff[2];
			FMC_ADDR_TEMP_D: nxt_rdata = temp_ff[3];
			FMC_ADDR_CURMON: nxt_rdata = cmon_ff[9:2];
			FMC_ADDR_TERMV:  nxt_rdata = tvolt_ff[9:2];
			FMC_ADDR_EXTRES: nxt_rdata = {cmon_ff[1:0], tvolt_ff[1:0], FMC_EXT_RSVD};
			default:         nxt_rdata = FMC_UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg6_ff      <= FMC_CFG6_RST;
			cfg7_ff      <= FMC_CFG7_RST;
			cmon_ff      <= {FMC_MEAS_RST, 2'b00};
			tvolt_ff     <= {FMC_MEAS_RST, 2'b00};
			frz_ff       <= 1'b0;
			cmon_rd_ff   <= 1'b0;
			tvolt_rd_ff  <= 1'b0;
			rdata_ff     <= FMC_UNMAPPED_DATA;
			rvalid_ff    <= 1'b0;
			stby_sync_ff <= 2'b00;
			vlow_sync_ff <= 2'b00;
		end else begin
			cfg6_ff      <= nxt_cfg6;
			cfg7_ff      <= nxt_cfg7;
			cmon_ff      <= nxt_cmon;
			tvolt_ff     <= nxt_tvolt;
			frz_ff       <= nxt_frz;
			cmon_rd_ff   <= nxt_cmon_rd;
			tvolt_rd_ff  <= nxt_tvolt_rd;
			rdata_ff     <= req.rd ? nxt_rdata : rdata_ff;
			rvalid_ff    <= req.rd;
			stby_sync_ff <= {stby_sync_ff[0], standby_pin};
			vlow_sync_ff <= {vlow_sync_ff[0], vcore_low_pin};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slow_x4_ff                     <= 3'h0;
			extended_smoothing_ff          <= 1'b0;
			overtemp_hysteresis_disable_ff <= 1'b0;
			full_speed_override_ff         <= 1'b0;
			watts_display_flag_ff          <= 1'b0;
			pulse_spinup_disable_ff        <= 1'b0;
			bus_timeout_disable_ff         <= 1'b0;
		end else begin
			slow_x4_ff <= {nxt_cfg6[FMC_B_SLOW_R2], nxt_cfg6[FMC_B_SLOW_LOC],
				nxt_cfg6[FMC_B_SLOW_R1]};
			extended_smoothing_ff          <= nxt_cfg6[FMC_B_XSLOW];
			overtemp_hysteresis_disable_ff <= nxt_cfg7[FMC_B_HYS_DIS];
			full_speed_override_ff         <= nxt_cfg7[FMC_B_FULL_SPD];
			watts_display_flag_ff          <= nxt_cfg7[FMC_B_WATTS];
			pulse_spinup_disable_ff        <= nxt_cfg7[FMC_B_SPIN_DIS];
			bus_timeout_disable_ff         <= nxt_cfg7[FMC_B_TO_DIS];
		end
	end

	fmc_sleep_ctrl u_sleep (
		.clk           (clk),
		.arst_n        (arst_n),
		.sleep_en      (cfg6_ff[FMC_B_VLOW]),
		.on_standby    (stby_sync_ff[1]),
		.vcore_below   (vlow_sync_ff[1]),
		.alert_en      (alert_en),
		.status_clr    (status_clr),
		.status_ff     (vlow_status_ff),
		.alert_ff      (alert_ff),
		.hot_mon_en_ff (hot_mon_en_ff),
		.spinup_req_ff (spinup_req_ff)
	);
endmodule
`default_nettype wire

//--- bench/fmc_regbank_properties.sv
// checker: port-level timing of the fan monitor register bank
`timescale 1ns/10ps
`default_nettype none
module fmc_regbank_properties
	import fmc_pkg::*;
(
	input wire logic        clk,                            // system clock
	input wire logic        arst_n,                         // async reset, active low
	input wire fmc_req_type req,                            // register access
	input wire logic        lock,                           // configuration lock
	input wire logic        alert_en,                       // alert enable
	input wire logic [7:0]  rdata_ff,                       // read data
	input wire logic        rvalid_ff,                      // read strobe
	input wire logic [2:0]  slow_x4_ff,                     // x4 smoothing bits
	input wire logic        extended_smoothing_ff,          // extra smoothing
	input wire logic        overtemp_hysteresis_disable_ff, // hysteresis off
	input wire logic        full_speed_override_ff,         // full speed
	input wire logic        watts_display_flag_ff,          // watts hint
	input wire logic        pulse_spinup_disable_ff,        // long spin-up
	input wire logic        bus_timeout_disable_ff,         // timeout off
	input wire logic        vlow_status_ff,                 // low-core status
	input wire logic        alert_ff,                       // alert output
	input wire logic        hot_mon_en_ff,                  // hot monitoring on
	input wire logic        spinup_req_ff                   // wake spin-up
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_read_answer: assert property (req.rd |=> rvalid_ff)
		else $error("read got no answer");
	chk_no_stray: assert property (!req.rd |=> !rvalid_ff && $stable(rdata_ff))
		else $error("read data moved without read");
	chk_cfg6_locked: assert property (lock && req.wr && req.addr == 8'h10
		|=> $stable({slow_x4_ff, extended_smoothing_ff})) else $error("locked cfg6 changed");
	chk_cfg6_write: assert property (!lock && req.wr && req.addr == 8'h10
		|=> slow_x4_ff == $past(req.wdata[2:0]) && extended_smoothing_ff == $past(req.wdata[7]))
		else $error("cfg6 outputs wrong");
	chk_cfg7_write: assert property (!lock && req.wr && req.addr == 8'h11
		|=> {bus_timeout_disable_ff, pulse_spinup_disable_ff, watts_display_flag_ff,
		overtemp_hysteresis_disable_ff} == $past({req.wdata[4:2], req.wdata[0]}))
		else $error("cfg7 outputs wrong");
	chk_full_speed_override_free: assert property (req.wr && req.addr == 8'h11
		|=> full_speed_override_ff == $past(req.wdata[1])) else $error("full speed not written");
	chk_alert_status: assert property (alert_ff == (vlow_status_ff && $past(alert_en)))
		else $error("alert wrong");
	chk_hot_stop: assert property ($fell(hot_mon_en_ff) |-> vlow_status_ff)
		else $error("hot monitoring stopped without status");
	chk_wake_spin: assert property ($rose(hot_mon_en_ff) |-> ##[0:1] spinup_req_ff)
		else $error("no spin-up on wake");
endmodule
`default_nettype wire

//--- bench/fmc_host_model.sv
// host model: issues single register reads and writes to the bank
`timescale 1ns/10ps
`default_nettype none
module fmc_host_model
	import fmc_pkg::*;
(
	input  wire logic       clk,       // system clock
	input  wire logic [7:0] rdata_ff,  // read data
	input  wire logic       rvalid_ff, // read strobe
	output var fmc_req_type req        // request to the bank
);
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, (a == 8'h11) ? (d & 8'h1F) : d};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 8'hA5};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, 8'h5A};
		#1;
		d = (rvalid_ff === 1'b1) ? rdata_ff : 8'hXX;
	endtask
endmodule
`default_nettype wire

//--- bench/fan_monitor_config_readings_tb.sv
// testbench: random and corner accesses to the fan monitor register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module fan_monitor_config_readings_tb
	import fmc_pkg::*;
;
	logic clk, arst_n, lock, standby_pin, vcore_low_pin, alert_en, status_clr, rvalid_ff;
	logic [7:0] temp_in [4];
	logic [7:0] te [4];
	logic [7:0] ta [4];
	logic [3:0] temp_vld;
	fmc_meas_type current_monitor_input, termination_voltage_input;
	fmc_req_type req;
	logic [7:0] rdata_ff, seed, c6, c7, d;
	logic [2:0] slow_x4_ff;
	logic extended_smoothing_ff, overtemp_hysteresis_disable_ff, full_speed_override_ff;
	logic watts_display_flag_ff, pulse_spinup_disable_ff, bus_timeout_disable_ff;
	logic vlow_status_ff, alert_ff, hot_mon_en_ff, spinup_req_ff;
	logic sp_seen = 1'b0;
	logic [4:0] cfg7_out;
	logic [9:0] iv, vv;
	int fails, n_tests, k;
	assign cfg7_out = {bus_timeout_disable_ff, pulse_spinup_disable_ff, watts_display_flag_ff,
		full_speed_override_ff, overtemp_hysteresis_disable_ff};
	fmc_regbank i_dut (.clk, .arst_n, .req, .lock, .temp_in, .temp_vld, .current_monitor_input,
		.termination_voltage_input,
		.standby_pin, .vcore_low_pin, .alert_en, .status_clr, .rdata_ff, .rvalid_ff, .slow_x4_ff,
		.extended_smoothing_ff, .overtemp_hysteresis_disable_ff, .full_speed_override_ff,
		.watts_display_flag_ff, .pulse_spinup_disable_ff, .bus_timeout_disable_ff,
		.vlow_status_ff, .alert_ff, .hot_mon_en_ff, .spinup_req_ff);
	fmc_host_model i_host (.clk, .rdata_ff, .rvalid_ff, .req);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] ext(input logic [9:0] i, input logic [9:0] v);
		return {i[1:0], v[1:0], 4'h0};
	endfunction
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] g;
		i_host.rd(a, g);
		`CHK(nm, e, g)
	endtask
	task automatic meas(input logic [9:0] i, input logic [9:0] v);
		@(posedge clk);
		current_monitor_input <= '{1'b1, i};
		termination_voltage_input <= '{1'b1, v};
		@(posedge clk);
		current_monitor_input <= '{1'b0, ~i};
		termination_voltage_input <= '{1'b0, ~v};
	endtask
	task results;
		$display("fails %0d n_tests %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (spinup_req_ff === 1'b1) sp_seen <= 1'b1;
	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		results();
	end
	initial begin
		arst_n = 0; lock = 0; standby_pin = 0; vcore_low_pin = 0; alert_en = 0; status_clr = 0;
		temp_in = '{default: 8'h00};
		temp_vld = 4'h0;
		current_monitor_input = '0;
		termination_voltage_input = '0;
		seed = 8'h37;
		fails = 0;
		n_tests = 0;
		ta = '{FMC_ADDR_TEMP_A, FMC_ADDR_TEMP_B, FMC_ADDR_TEMP_C, FMC_ADDR_TEMP_D};
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rdc(FMC_ADDR_CFG6, 8'h00, "cfg6");
		rdc(FMC_ADDR_CFG7, 8'h00, "cfg7");
		for (k = 0; k < 4; k++) rdc(ta[k], 8'h80, "temp");
		rdc(FMC_ADDR_CURMON, 8'h00, "cur mon");
		rdc(FMC_ADDR_TERMV, 8'h00, "term volt");
		rdc(8'h50, 8'h00, "unmapped");
		for (k = 0; k < 10; k++) begin
			seed = lfsr(seed); c6 = (k == 0) ? 8'hFF : seed & 8'hBF;
			i_host.wr(FMC_ADDR_CFG6, c6);
			seed = lfsr(seed); c7 = (k == 0) ? 8'hFF : seed;
			i_host.wr(FMC_ADDR_CFG7, c7);
			rdc(FMC_ADDR_CFG6, c6 & 8'hC7, "cfg6");
			rdc(FMC_ADDR_CFG7, c7 & 8'h1F, "cfg7");
			`CHK("slow", c6[2:0], slow_x4_ff)
			`CHK("xslow", c6[7], extended_smoothing_ff)
			`CHK("cfg7 out", c7[4:0], cfg7_out)
		end
		i_host.wr(FMC_ADDR_CFG6, 8'h40);
		alert_en <= 1'b1; standby_pin <= 1'b1; vcore_low_pin <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		`CHK("sleep", 3'b110, {vlow_status_ff, alert_ff, hot_mon_en_ff})
		@(posedge clk);
		vcore_low_pin <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		`CHK("wake", 2'b11, {hot_mon_en_ff, sp_seen})
		@(posedge clk);
		status_clr <= 1'b1;
		@(posedge clk);
		status_clr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("clear", 2'b00, {vlow_status_ff, alert_ff})
		@(posedge clk);
		for (k = 0; k < 4; k++) begin seed = lfsr(seed); te[k] = seed; temp_in[k] <= seed; end
		temp_vld <= 4'hF;
		@(posedge clk);
		temp_vld <= 4'h0;
		for (k = 0; k < 4; k++) rdc(ta[k], te[k], "temp");
		seed = lfsr(seed); iv = {seed, 2'b10}; vv = {~seed, 2'b01};
		meas(iv, vv);
		rdc(FMC_ADDR_EXTRES, ext(iv, vv), "ext");
		meas(~iv, ~vv);
		rdc(FMC_ADDR_CURMON, iv[9:2], "cur mon frozen");
		rdc(FMC_ADDR_TERMV, vv[9:2], "term volt frozen");
		iv = ~iv; vv = ~vv;
		meas(iv, vv);
		rdc(FMC_ADDR_CURMON, iv[9:2], "cur mon");
		rdc(FMC_ADDR_TERMV, vv[9:2], "term volt");
		@(posedge clk);
		lock <= 1'b1;
		i_host.wr(FMC_ADDR_CFG6, 8'h87);
		rdc(FMC_ADDR_CFG6, 8'h40, "cfg6 locked");
		d = ~c7 & 8'h1F;
		i_host.wr(FMC_ADDR_CFG7, d);
		rdc(FMC_ADDR_CFG7, (c7 & 8'h1D) | (d & 8'h02), "cfg7 locked");
		`CHK("full_speed_override", d[1], full_speed_override_ff)
		// mid-run reset: config and sleep outputs, temp a, extended and cfg7 registers back at reset value
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		#1;
		`CHK("reset cfg", 9'h000, {slow_x4_ff, extended_smoothing_ff, cfg7_out})
		`CHK("reset sleep", 4'h2, {vlow_status_ff, alert_ff, hot_mon_en_ff, spinup_req_ff})
		rdc(FMC_ADDR_TEMP_A, FMC_TEMP_RST, "temp reset");
		rdc(FMC_ADDR_EXTRES, 8'h00, "ext reset");
		rdc(FMC_ADDR_CFG7, FMC_CFG7_RST, "cfg7 reset");
		results();
	end
endmodule
bind fmc_regbank fmc_regbank_properties i_chk (.clk, .arst_n, .req, .lock, .alert_en, .rdata_ff,
	.rvalid_ff, .slow_x4_ff, .extended_smoothing_ff, .overtemp_hysteresis_disable_ff,
	.full_speed_override_ff, .watts_display_flag_ff, .pulse_spinup_disable_ff,
	.bus_timeout_disable_ff, .vlow_status_ff, .alert_ff, .hot_mon_en_ff, .spinup_req_ff);
`default_nettype wire
